// file: fs_pkg.sv
// Purpose: Shared constants for the failsafe supervisor
// Assumes: 125 MHz system clock, 32-bit classic Wishbone
// Notes:   Byte offsets of the register map are word aligned

package fs_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ      = 125_000_000;
   localparam int unsigned SILENCE_S   = 45;
   localparam int unsigned SUPPRESS_S  = 10;
   localparam int unsigned HOUR_MIN    = 60;
   localparam int unsigned SEC_PER_MIN = 60;

   // ----------------------------------------
   // Converter thresholds in counts (1 mV per count)
   // ----------------------------------------
   localparam logic [12:0] LOW_COUNTS = 13'h0100;
   localparam logic [12:0] SAT_COUNTS = 13'h1800;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [4:0] CTRL_ADR  = 5'h00;
   localparam logic [4:0] STAT_ADR  = 5'h04;
   localparam logic [4:0] VIEW_ADR  = 5'h08;
   localparam logic [4:0] VALUE_ADR = 5'h0c;
   localparam logic [4:0] SLOT_ADR  = 5'h10;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned CTRL_HOLD_BIT  = 0;
   localparam int unsigned CTRL_ACK_BIT   = 1;
   localparam int unsigned STAT_FS_BIT    = 0;
   localparam int unsigned STAT_SIL_BIT   = 1;
   localparam int unsigned STAT_MET_BIT   = 2;
   localparam int unsigned STAT_INH_BIT   = 3;
   localparam int unsigned STAT_ALARM_BIT = 4;
   localparam int unsigned STAT_ALEN_BIT  = 5;
   localparam int unsigned VIEW_ERR_BIT   = 8;
   localparam int unsigned VIEW_REM_LSB   = 16;
   localparam int unsigned VALUE_SAT_BIT  = 16;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] VIEW_RST = 8'h01;
   localparam logic [7:0] SLOT_RST = 8'h00;

   typedef enum logic [0:0] {
      MODE_RUN  = 1'b0,
      MODE_HOLD = 1'b1
   } mode_type;

endpackage

// file: fs_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to CLK_I
// Notes:   Only the second stage is visible outside

`timescale 1ns/1ps

module fs_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_state_type;

   sync_state_type s;
   sync_state_type next_s;

   always_comb begin
      next_s = s;
      if (ce_i) begin
         next_s.meta = d_i;
         next_s.sync = s.meta;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q_o = s.sync;

endmodule

// file: fs_timer.sv
// Purpose: Down counter that reloads to a full interval
// Assumes: tick_i is a one-cycle timebase pulse
// Notes:   Stops at zero; done_o follows the stored count

`timescale 1ns/1ps

module fs_timer #(
   parameter int unsigned W    = 8,
   parameter int unsigned LOAD = 45
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic         ce_i,
   input  wire logic         reload_i,
   input  wire logic         tick_i,
   output logic      [W-1:0] rem_o,
   output logic              done_o
);

   localparam logic [W-1:0] FULL = W'(LOAD);

   typedef struct packed {
      logic [W-1:0] rem;
   } timer_state_type;

   timer_state_type s;
   timer_state_type next_s;

   generate
      if (LOAD == 0 || LOAD >= (2 ** W)) begin : g_chk
         $error("fs_timer: LOAD does not fit W");
      end
   endgenerate

   always_comb begin
      next_s = s;
      if (ce_i) begin
         if (reload_i) begin
            next_s.rem = FULL;
         end else if (tick_i && s.rem != '0) begin
            next_s.rem = s.rem - W'(1);
         end
      end
   end

   // Full interval from reset on
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s.rem <= FULL;
      end else begin
         s <= next_s;
      end
   end

   assign rem_o  = s.rem;
   assign done_o = (s.rem == '0);

endmodule

// file: failsafe_supervisor.sv
// Purpose: Failsafe supervisor of a remote-control terminal
// Assumes: Link decoder and converter share CLK_I; keys are pins
// Notes:   One-second timebase divided down from CLK_I
//
// What this block does
// - Assert failsafe after 45 s without a valid addressed message.
// - A valid message or entering service hold ends the link-silence trip.
// - Single failsafe output, set by either trip or both.
// - Four monitor slots hold telemetry input numbers; zero unassigns.
// - Any unassigned slot inhibits the metering-loss trip.
// - With all slots set, any input below 256 mV starts one-hour countdown.
// - One hour without link communication also raises the metering-loss trip.
// - Reading a slot returns its input number, or zero.
// - Channel zero view shows minutes left until trip, 60 when healthy.
// - Channel zero selection refused with error while trip is inhibited.
// - Any active trip blocks every command output.
// - Entering service hold clears trips and re-enables commands.
// - Leaving service hold reloads all three trip intervals in full.
// - All four monitored inputs at zero ends the metering-loss trip.
// - In service hold, control terminal raise and lower are ignored.
// - Alarms suppressed for ten seconds after reset.
// - Converter reading at 6144 counts shows the saturation pattern.
// - Relay contact open while any trip is active, closed otherwise.
// - Outside service hold, local raise and lower are disabled.
// - Hold key toggles service hold; its indicator lights while active.

`timescale 1ns/1ps

module failsafe_supervisor #(
   parameter int unsigned CHW      = 5,
   parameter int unsigned TICKS_PS = fs_pkg::CLK_HZ
) (
   // Clock, reset, enable
   input  wire logic          CLK_I,
   input  wire logic          RSTN_I,
   input  wire logic          CE_I,
   // Wishbone slave
   input  wire logic          CYC_I,
   input  wire logic          STB_I,
   input  wire logic          WE_I,
   input  wire logic [4:2]    ADR_I,
   input  wire logic [3:0]    SEL_I,
   input  wire logic [31:0]   DAT_I,
   output logic      [31:0]   DAT_O,
   output logic               ACK_O,
   // Link decoder
   input  wire logic          MSG_OK_I,
   input  wire logic          CTRL_RAISE_I,
   input  wire logic          CTRL_LOWER_I,
   // Converter samples
   input  wire logic          ADC_VALID_I,
   input  wire logic [CHW-1:0] ADC_CHAN_I,
   input  wire logic [12:0]   ADC_DATA_I,
   // Front-panel keys
   input  wire logic          HOLD_KEY_I,
   input  wire logic          LOCAL_RAISE_I,
   input  wire logic          LOCAL_LOWER_I,
   // Outputs
   output logic               FAILSAFE_O,
   output logic               RELAY_CLOSED_O,
   output logic               HOLD_LED_O,
   output logic               RAISE_O,
   output logic               LOWER_O,
   output logic               ALARM_O
);

   localparam int unsigned DIVW = $clog2(TICKS_PS);
   localparam logic [DIVW-1:0] DIV_LAST = DIVW'(TICKS_PS - 1);
   localparam logic [5:0] MIN_LAST = 6'(fs_pkg::SEC_PER_MIN - 1);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   generate
      if (TICKS_PS < 2 || CHW < 1 || CHW > 8) begin : g_chk
         $error("failsafe_supervisor: unsupported parameters");
      end
   endgenerate

   typedef struct packed {
      logic                ack;
      logic [31:0]         dat;
      logic [3:0][CHW-1:0] slot;
      fs_pkg::mode_type    mode;
      logic                key_q;
      logic [3:0]          low;
      logic [3:0]          zero;
      logic [CHW-1:0]      view;
      logic                err;
      logic [12:0]         value;
      logic                sat;
      logic                sil_trip;
      logic                met_trip;
      logic                alarm;
      logic                fs;
      logic                relay;
      logic                raise;
      logic                lower;
      logic [DIVW-1:0]     div;
      logic                sec_tick;
      logic [5:0]          sec_cnt;
      logic                min_tick;
   } state_type;

   state_type s;
   state_type next_s;

   // ----------------------------------------
   // Pins and timers
   // ----------------------------------------
   logic [2:0] keys;
   logic [7:0] sil_rem;
   logic [7:0] sup_rem;
   logic [7:0] tlm_rem;
   logic [7:0] link_rem;
   logic       sil_done;
   logic       sup_done;
   logic       tlm_done;
   logic       link_done;
   logic       hold;
   logic       assigned;
   logic       sil_reload;
   logic       tlm_reload;

   fs_sync #(.W(3)) u_sync (
      .clk_i  (CLK_I),
      .rstn_i (RSTN_I),
      .ce_i   (CE_I),
      .d_i    ({LOCAL_LOWER_I, LOCAL_RAISE_I, HOLD_KEY_I}),
      .q_o    (keys)
   );

   assign hold     = (s.mode == fs_pkg::MODE_HOLD);
   assign assigned = (s.slot[0] != '0) && (s.slot[1] != '0)
                  && (s.slot[2] != '0) && (s.slot[3] != '0);
   // Held in reload during hold, so leaving it restarts in full
   assign sil_reload = MSG_OK_I | hold;
   assign tlm_reload = hold | !assigned | (s.low == 4'h0);

   fs_timer #(.W(8), .LOAD(fs_pkg::SILENCE_S)) u_sil (
      .clk_i    (CLK_I),
      .rstn_i   (RSTN_I),
      .ce_i     (CE_I),
      .reload_i (sil_reload),
      .tick_i   (s.sec_tick),
      .rem_o    (sil_rem),
      .done_o   (sil_done)
   );

   fs_timer #(.W(8), .LOAD(fs_pkg::SUPPRESS_S)) u_sup (
      .clk_i    (CLK_I),
      .rstn_i   (RSTN_I),
      .ce_i     (CE_I),
      .reload_i (1'b0),
      .tick_i   (s.sec_tick),
      .rem_o    (sup_rem),
      .done_o   (sup_done)
   );

   fs_timer #(.W(8), .LOAD(fs_pkg::HOUR_MIN)) u_tlm (
      .clk_i    (CLK_I),
      .rstn_i   (RSTN_I),
      .ce_i     (CE_I),
      .reload_i (tlm_reload),
      .tick_i   (s.min_tick),
      .rem_o    (tlm_rem),
      .done_o   (tlm_done)
   );

   fs_timer #(.W(8), .LOAD(fs_pkg::HOUR_MIN)) u_link (
      .clk_i    (CLK_I),
      .rstn_i   (RSTN_I),
      .ce_i     (CE_I),
      .reload_i (sil_reload),
      .tick_i   (s.min_tick),
      .rem_o    (link_rem),
      .done_o   (link_done)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic       press;
      logic       wr;
      logic       rd;
      logic       trip;
      logic [4:0] adr;
      next_s = s;
      press  = 1'b0;
      trip   = 1'b0;
      adr    = {ADR_I, 2'b00};
      wr     = CYC_I && STB_I && !s.ack && WE_I && SEL_I[0];
      rd     = CYC_I && STB_I && !s.ack;
      if (CE_I) begin
         // Timebase: seconds, then whole minutes
         next_s.sec_tick = (s.div == DIV_LAST);
         next_s.div      = next_s.sec_tick ? '0 : s.div + DIVW'(1);
         next_s.min_tick = s.sec_tick && (s.sec_cnt == MIN_LAST);
         if (s.sec_tick) begin
            next_s.sec_cnt = (s.sec_cnt == MIN_LAST) ? 6'h00 : s.sec_cnt + 6'h01;
         end

         // Hold key from pin edge or software press
         next_s.key_q = keys[0];
         press = (keys[0] && !s.key_q)
              || (wr && adr == fs_pkg::CTRL_ADR && DAT_I[fs_pkg::CTRL_HOLD_BIT]);
         if (press) begin
            next_s.mode = hold ? fs_pkg::MODE_RUN : fs_pkg::MODE_HOLD;
         end

         // Slot writes; a new number forgets the old reading
         for (int k = 0; k < 4; k++) begin
            if (wr && adr == fs_pkg::SLOT_ADR + 5'(4 * k)) begin
               next_s.slot[k] = DAT_I[CHW-1:0];
               next_s.low[k]  = 1'b0;
               next_s.zero[k] = 1'b0;
            end else if (ADC_VALID_I && s.slot[k] != '0 && ADC_CHAN_I == s.slot[k]) begin
               next_s.low[k]  = (ADC_DATA_I < fs_pkg::LOW_COUNTS);
               next_s.zero[k] = (ADC_DATA_I == 13'h0000);
            end
         end

         // View selection; channel zero refused while inhibited
         if (wr && adr == fs_pkg::VIEW_ADR) begin
            if (DAT_I[CHW-1:0] == '0 && !assigned) begin
               next_s.err = 1'b1;
            end else begin
               next_s.view = DAT_I[CHW-1:0];
               next_s.err  = 1'b0;
            end
         end
         if (ADC_VALID_I && s.view != '0 && ADC_CHAN_I == s.view) begin
            next_s.value = ADC_DATA_I;
            next_s.sat   = (ADC_DATA_I >= fs_pkg::SAT_COUNTS);
         end

         // Trips
         if (next_s.mode == fs_pkg::MODE_HOLD || MSG_OK_I) begin
            next_s.sil_trip = 1'b0;
         end else if (sil_done) begin
            next_s.sil_trip = 1'b1;
         end
         if (next_s.mode == fs_pkg::MODE_HOLD) begin
            next_s.met_trip = 1'b0;
         end else if (!assigned) begin
            next_s.met_trip = 1'b0;
         end else if (s.zero == 4'hf) begin
            next_s.met_trip = 1'b0;
         end else if (tlm_done || link_done) begin
            next_s.met_trip = 1'b1;
         end
         trip = next_s.sil_trip || next_s.met_trip;
         next_s.fs    = trip;
         next_s.relay = !trip;

         // Alarm on trip onset; onset wins over acknowledge
         if (trip && !s.fs && sup_done) begin
            next_s.alarm = 1'b1;
         end else if (wr && adr == fs_pkg::CTRL_ADR && DAT_I[fs_pkg::CTRL_ACK_BIT]) begin
            next_s.alarm = 1'b0;
         end

         // Command gating by mode and trips
         if (trip) begin
            next_s.raise = 1'b0;
            next_s.lower = 1'b0;
         end else if (next_s.mode == fs_pkg::MODE_HOLD) begin
            next_s.raise = keys[1];
            next_s.lower = keys[2];
         end else begin
            next_s.raise = CTRL_RAISE_I;
            next_s.lower = CTRL_LOWER_I;
         end

         // Bus answer one cycle after the request
         next_s.ack = rd;
         next_s.dat = 32'h0000_0000;
         if (rd) begin
            if (adr == fs_pkg::CTRL_ADR) begin
               next_s.dat[fs_pkg::CTRL_HOLD_BIT] = hold;
            end else if (adr == fs_pkg::STAT_ADR) begin
               next_s.dat[fs_pkg::STAT_FS_BIT]    = s.fs;
               next_s.dat[fs_pkg::STAT_SIL_BIT]   = s.sil_trip;
               next_s.dat[fs_pkg::STAT_MET_BIT]   = s.met_trip;
               next_s.dat[fs_pkg::STAT_INH_BIT]   = !assigned;
               next_s.dat[fs_pkg::STAT_ALARM_BIT] = s.alarm;
               next_s.dat[fs_pkg::STAT_ALEN_BIT]  = sup_done;
            end else if (adr == fs_pkg::VIEW_ADR) begin
               next_s.dat[CHW-1:0] = s.view;
               next_s.dat[fs_pkg::VIEW_ERR_BIT] = s.err;
               next_s.dat[fs_pkg::VIEW_REM_LSB +: 8] = tlm_rem;
            end else if (adr == fs_pkg::VALUE_ADR) begin
               next_s.dat[12:0] = s.value;
               next_s.dat[fs_pkg::VALUE_SAT_BIT] = s.sat;
            end else if (adr >= fs_pkg::SLOT_ADR) begin
               next_s.dat[CHW-1:0] = s.slot[adr[3:2]];
            end
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         s       <= '0;
         s.relay <= 1'b1;
         s.view  <= CHW'(fs_pkg::VIEW_RST);
         s.slot  <= {4{CHW'(fs_pkg::SLOT_RST)}};
      end else begin
         s <= next_s;
      end
   end

   assign DAT_O          = s.dat;
   assign ACK_O          = s.ack;
   assign FAILSAFE_O     = s.fs;
   assign RELAY_CLOSED_O = s.relay;
   assign HOLD_LED_O     = (s.mode == fs_pkg::MODE_HOLD);
   assign RAISE_O        = s.raise;
   assign LOWER_O        = s.lower;
   assign ALARM_O        = s.alarm;

endmodule

// file: fs_props.sv
// Purpose: Concurrent checks on the failsafe supervisor ports
// Assumes: CE_I is held high while checks run
// Notes:   Bound into every failsafe_supervisor instance
`timescale 1ns/1ps
module fs_checker #(
   parameter int unsigned TICKS_PS = 4
) (
   // Clock, reset, enable
   input wire logic        CLK_I,
   input wire logic        RSTN_I,
   input wire logic        CE_I,
   // Bus
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   // Link and keys
   input wire logic        MSG_OK_I,
   input wire logic        CTRL_RAISE_I,
   input wire logic        CTRL_LOWER_I,
   input wire logic        LOCAL_RAISE_I,
   // Outputs
   input wire logic        FAILSAFE_O,
   input wire logic        RELAY_CLOSED_O,
   input wire logic        HOLD_LED_O,
   input wire logic        RAISE_O,
   input wire logic        LOWER_O,
   input wire logic        ALARM_O
);
   // Margin covers the unknown phase of the one-second pulse
   localparam int SIL_MAX = 46 * TICKS_PS + 2;
   localparam int SUP_MIN = 9 * TICKS_PS;
   logic [31:0] quiet;
   logic [31:0] up_time;
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         quiet   <= 32'h0000_0000;
         up_time <= 32'h0000_0000;
      end else begin
         quiet   <= (MSG_OK_I || HOLD_LED_O) ? 32'h0000_0000 : quiet + 32'h0000_0001;
         up_time <= up_time + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   relay_vs_fs_a: assert property (RELAY_CLOSED_O == !FAILSAFE_O)
      else $error("relay contact disagrees with failsafe");
   cmd_block_a: assert property (FAILSAFE_O |-> !RAISE_O && !LOWER_O)
      else $error("command output during trip");
   hold_clear_a: assert property (HOLD_LED_O |-> !FAILSAFE_O)
      else $error("trip active in service hold");
   silence_trip_a: assert property (quiet == SIL_MAX && !HOLD_LED_O |-> FAILSAFE_O)
      else $error("no failsafe after link silence");
   alarm_quiet_a: assert property ($rose(ALARM_O) |-> up_time >= SUP_MIN)
      else $error("alarm inside suppress window");
   ack_once_a: assert property (ACK_O |=> !ACK_O)
      else $error("ack longer than one cycle");
   ack_next_a: assert property (CE_I && CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("ack not one cycle after request");
   dat_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
      else $error("read data outside ack");
   hold_cmd_a: assert property (RAISE_O && HOLD_LED_O |-> $past(LOCAL_RAISE_I, 3))
      else $error("raise in hold without local key");
   run_raise_a: assert property (RAISE_O && !HOLD_LED_O |-> $past(CTRL_RAISE_I))
      else $error("raise outside hold without terminal command");
   run_lower_a: assert property (LOWER_O && !HOLD_LED_O |-> $past(CTRL_LOWER_I))
      else $error("lower outside hold without terminal command");
endmodule
bind failsafe_supervisor fs_checker #(.TICKS_PS(TICKS_PS)) u_fs_checker (
   .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
   .ACK_O(ACK_O), .MSG_OK_I(MSG_OK_I), .CTRL_RAISE_I(CTRL_RAISE_I), .CTRL_LOWER_I(CTRL_LOWER_I),
   .LOCAL_RAISE_I(LOCAL_RAISE_I), .FAILSAFE_O(FAILSAFE_O), .RELAY_CLOSED_O(RELAY_CLOSED_O),
   .HOLD_LED_O(HOLD_LED_O), .RAISE_O(RAISE_O), .LOWER_O(LOWER_O), .ALARM_O(ALARM_O));

// file: ctrl_terminal_model.sv
// Purpose: Control terminal seen through the link decoder
// Assumes: Decoder hands over one pulse per valid addressed message
// Notes:   gap_i zero keeps the link silent
`timescale 1ns/1ps
module ctrl_terminal_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Scenario control
   input  wire logic [7:0] gap_i,
   input  wire logic [1:0] cmd_i,
   // Decoder side
   output logic            msg_ok_o,
   output logic            raise_o,
   output logic            lower_o
);
   logic [7:0] cnt;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt      <= 8'h00;
         msg_ok_o <= 1'b0;
         raise_o  <= 1'b0;
         lower_o  <= 1'b0;
      end else begin
         msg_ok_o <= (gap_i != 8'h00) && (cnt >= gap_i - 8'h01);
         cnt      <= (cnt >= gap_i - 8'h01) ? 8'h00 : cnt + 8'h01;
         raise_o  <= cmd_i[0];
         lower_o  <= cmd_i[1];
      end
   end
endmodule

// file: failsafe_supervisor_tb_top.sv
// Purpose: Self-checking bench for the failsafe supervisor
// Assumes: One-second timebase shortened to T cycles
// Notes:   Table rows cover registers; trips are hand-written
`timescale 1ns/1ps
module failsafe_supervisor_tb_top;
   localparam int T = 4;
   localparam logic [2:0] A_CTRL = fs_pkg::CTRL_ADR[4:2];
   localparam logic [2:0] A_STAT = fs_pkg::STAT_ADR[4:2];
   localparam logic [2:0] A_VIEW = fs_pkg::VIEW_ADR[4:2];
   localparam logic [2:0] A_VAL  = fs_pkg::VALUE_ADR[4:2];
   localparam logic [2:0] A_SLOT = fs_pkg::SLOT_ADR[4:2];
   typedef struct packed {logic we; logic [2:0] a; logic [31:0] d; logic [31:0] e;} row_type;
   logic        CLK_I, RSTN_I, CE_I, CYC_I, STB_I, WE_I, ACK_O, MSG_OK_I, CTRL_RAISE_I, CTRL_LOWER_I;
   logic        ADC_VALID_I, HOLD_KEY_I, LOCAL_RAISE_I, LOCAL_LOWER_I, FAILSAFE_O, RELAY_CLOSED_O;
   logic        HOLD_LED_O, RAISE_O, LOWER_O, ALARM_O;
   logic [2:0]  ADR_I;
   logic [3:0]  SEL_I;
   logic [31:0] DAT_I, DAT_O;
   logic [4:0]  ADC_CHAN_I;
   logic [12:0] ADC_DATA_I;
   logic [7:0]  gap;
   logic [1:0]  cmd;
   int          bad_count, total_checks;
   row_type     rows [0:16];
   logic [4:0]  mons [0:3] = '{5'h0d, 5'h0f, 5'h11, 5'h19};
   failsafe_supervisor #(.CHW(5), .TICKS_PS(T)) u_dut (
      .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
      .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .MSG_OK_I(MSG_OK_I),
      .CTRL_RAISE_I(CTRL_RAISE_I), .CTRL_LOWER_I(CTRL_LOWER_I), .ADC_VALID_I(ADC_VALID_I),
      .ADC_CHAN_I(ADC_CHAN_I), .ADC_DATA_I(ADC_DATA_I), .HOLD_KEY_I(HOLD_KEY_I),
      .LOCAL_RAISE_I(LOCAL_RAISE_I), .LOCAL_LOWER_I(LOCAL_LOWER_I), .FAILSAFE_O(FAILSAFE_O),
      .RELAY_CLOSED_O(RELAY_CLOSED_O), .HOLD_LED_O(HOLD_LED_O), .RAISE_O(RAISE_O),
      .LOWER_O(LOWER_O), .ALARM_O(ALARM_O));
   ctrl_terminal_model u_term (.clk_i(CLK_I), .rstn_i(RSTN_I), .gap_i(gap), .cmd_i(cmd),
      .msg_ok_o(MSG_OK_I), .raise_o(CTRL_RAISE_I), .lower_o(CTRL_LOWER_I));
   initial begin
      CLK_I = 1'b0;
      forever #4 CLK_I = ~CLK_I;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge CLK_I);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I  <= we;
      ADR_I <= a;
      DAT_I <= d;
      SEL_I <= 4'hf;
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
      end while (ACK_O !== 1'b1 && n < 20);
      q = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      WE_I  <= 1'b0;
      if (n >= 20) begin
         chk(32'h0000_0000, 32'h0000_0001);
         stop_test();
      end
   endtask
   // Waits on the failsafe level; a hang counts as a mismatch
   task automatic wait_fs(input logic v, input int lim, output int n);
      n = 0;
      while (FAILSAFE_O !== v && n < lim) begin
         @(posedge CLK_I);
         n++;
      end
      if (n >= lim) begin
         chk(32'h0000_0000, 32'h0000_0001);
         stop_test();
      end
   endtask
   task automatic adc(input logic [4:0] ch, input logic [12:0] d);
      @(posedge CLK_I);
      ADC_VALID_I <= 1'b1;
      ADC_CHAN_I  <= ch;
      ADC_DATA_I  <= d;
      @(posedge CLK_I);
      ADC_VALID_I <= 1'b0;
   endtask
   task automatic one_msg();
      gap <= 8'h01;
      @(posedge CLK_I);
      gap <= 8'h00;
   endtask
   task automatic note(input string s);
      $display("done: %s", s);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int n;
      logic [31:0] q;
      {RSTN_I, CYC_I, STB_I, WE_I, ADC_VALID_I, HOLD_KEY_I, LOCAL_RAISE_I, LOCAL_LOWER_I} = 8'h00;
      {ADR_I, SEL_I, DAT_I, ADC_CHAN_I, ADC_DATA_I, cmd} = '0;
      CE_I = 1'b1;
      gap = 8'h32;
      rows = '{'{1'b0, A_STAT, 32'h0, 32'h0000_0008},
               '{1'b0, A_VIEW, 32'h0, 32'h003c_0001},
               '{1'b1, A_VIEW, 32'h0, 32'h0},
               '{1'b0, A_VIEW, 32'h0, 32'h003c_0101},
               '{1'b1, A_SLOT, 32'h0000_000d, 32'h0},
               '{1'b1, A_SLOT + 3'h1, 32'h0000_000f, 32'h0},
               '{1'b1, A_SLOT + 3'h2, 32'h0000_0011, 32'h0},
               '{1'b1, A_SLOT + 3'h3, 32'h0000_0019, 32'h0},
               '{1'b0, A_SLOT, 32'h0, 32'h0000_000d},
               '{1'b0, A_SLOT + 3'h3, 32'h0, 32'h0000_0019},
               '{1'b1, A_SLOT + 3'h1, 32'h0, 32'h0},
               '{1'b0, A_SLOT + 3'h1, 32'h0, 32'h0},
               '{1'b1, A_SLOT + 3'h1, 32'h0000_000f, 32'h0},
               '{1'b1, A_VIEW, 32'h0, 32'h0},
               '{1'b0, A_VIEW, 32'h0, 32'h003c_0000},
               '{1'b0, A_CTRL, 32'h0, 32'h0000_0000},
               '{1'b1, A_VIEW, 32'h0000_000d, 32'h0}};
      repeat (2) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         wb(rows[i].we, rows[i].a, rows[i].d, q);
         if (!rows[i].we) chk(q, rows[i].e);
      end
      note("register table");
      adc(5'h0d, 13'h1800);
      wb(1'b0, A_VAL, 32'h0, q);
      chk(q, 32'h0001_1800);
      adc(5'h0d, 13'h00ff);
      repeat (2 * 60 * T) @(posedge CLK_I);
      wb(1'b1, A_VIEW, 32'h0, q);
      wb(1'b0, A_VIEW, 32'h0, q);
      chk(32'(q[23:16] < 8'd60 && q[23:16] > 8'd56), 32'h0000_0001);
      wait_fs(1'b1, 60 * 60 * T + 100, n);
      chk(32'(n > 56 * 60 * T), 32'h0000_0001);
      chk(32'(RELAY_CLOSED_O), 32'h0000_0000);
      for (int i = 0; i < 4; i++) adc(mons[i], 13'h0000);
      wait_fs(1'b0, 10, n);
      note("metering loss");
      cmd <= 2'b11;
      repeat (6) @(posedge CLK_I);
      chk(32'({RAISE_O, LOWER_O}), 32'h0000_0003);
      one_msg();
      wait_fs(1'b1, 46 * T + 10, n);
      chk(32'(n >= 44 * T), 32'h0000_0001);
      chk(32'({LOWER_O, RAISE_O, RELAY_CLOSED_O, ALARM_O}), 32'h0000_0001);
      wb(1'b1, A_CTRL, 32'h0000_0002, q);
      wb(1'b0, A_STAT, 32'h0, q);
      chk(q, 32'h0000_0023);
      one_msg();
      wait_fs(1'b0, 6, n);
      note("link silence");
      wait_fs(1'b1, 46 * T + 10, n);
      HOLD_KEY_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      HOLD_KEY_I <= 1'b0;
      repeat (3) @(posedge CLK_I);
      chk(32'({HOLD_LED_O, FAILSAFE_O}), 32'h0000_0002);
      chk(32'({RAISE_O, LOWER_O}), 32'h0000_0000);
      LOCAL_RAISE_I <= 1'b1;
      repeat (5) @(posedge CLK_I);
      chk(32'({RAISE_O, LOWER_O}), 32'h0000_0002);
      LOCAL_RAISE_I <= 1'b0;
      repeat (300) @(posedge CLK_I);
      chk(32'(FAILSAFE_O), 32'h0000_0000);
      wb(1'b1, A_CTRL, 32'h0000_0001, q);
      repeat (2) @(posedge CLK_I);
      chk(32'(HOLD_LED_O), 32'h0000_0000);
      wait_fs(1'b1, 46 * T + 10, n);
      chk(32'(n >= 43 * T), 32'h0000_0001);
      note("service hold");
      RSTN_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      chk(32'({FAILSAFE_O, RELAY_CLOSED_O, HOLD_LED_O, ALARM_O}), 32'h0000_0004);
      RSTN_I <= 1'b1;
      wb(1'b0, A_STAT, 32'h0, q);
      chk(q, 32'h0000_0008);
      note("reset");
      stop_test();
   end
   initial begin
      repeat (100000) @(posedge CLK_I);
      chk(32'h0000_0000, 32'h0000_0001);
      stop_test();
   end
endmodule
